// file: src/rpt_pkg.sv
// Purpose: shared types and constants of the results print trigger
// Assumes: 250 MHz reference clock
// Notes: selector and setting encodings are local choices
package rpt_pkg;

	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned QUARTER_HOUR_S = 900;
	localparam int unsigned TWO_HOUR_S = 7200;
	localparam int unsigned SEC_W = 24;
	localparam int unsigned TICK_W = 32;

	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;

	typedef enum logic [2:0] {
		SEL_OFF = 3'h0,
		SEL_TEST_END = 3'h1,
		SEL_ERROR = 3'h2,
		SEL_SEV_ERR = 3'h3,
		SEL_TWO_HOUR = 3'h4,
		SEL_QUARTER_HOUR = 3'h5
	} rpt_sel_type;

	typedef enum logic [1:0] {
		FMT_NORMAL = 2'h0,
		FMT_SUMMARY = 2'h1,
		FMT_SHORT = 2'h2
	} rpt_fmt_type;

	typedef enum logic [1:0] {
		RATE_300 = 2'h0,
		RATE_1200 = 2'h1,
		RATE_2400 = 2'h2,
		RATE_4800 = 2'h3
	} rpt_rate_type;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ODD = 2'h1,
		PAR_EVEN = 2'h2
	} rpt_par_type;

	typedef enum logic [1:0] {
		TERM_IDLE = 2'h0,
		TERM_CR = 2'h1,
		TERM_LF = 2'h3
	} rpt_term_type;

	typedef struct packed {
		logic logic_err;
		logic crc_err;
		logic frame_err;
		logic bpv;
	} rpt_err_type;

	typedef struct packed {
		rpt_rate_type rate;
		rpt_par_type parity;
		logic crlf;
		logic dce;
	} rpt_serial_type;

	typedef struct packed {
		logic settings;
		rpt_fmt_type fmt;
	} rpt_req_type;

endpackage

// file: src/rpt_trigger.sv
// Purpose: decides when a results or settings report goes to the printer
// Assumes: front-panel buttons and selector are asynchronous pins
// Notes: report text itself is built by a formatter outside this block
//
// Behaviour
// R1 - manual results request emits a report of present measurements
// R2 - manual settings request emits a report of panel and auxiliary settings
// R3 - six selector positions choose the automatic results trigger
// R4 - selector off: no automatic reports or messages, manual only
// R5 - moving selector to off flushes all pending buffers unsent
// R6 - test-end mode reports when the timed test length expires
// R7 - error mode reports on any error event or alarm change
// R8 - severe second mode reports when error rate exceeds one in thousand
// R9 - severe second mode works only with performance option present
// R10 - two-hour mode reports every two hours
// R11 - quarter-hour mode reports every fifteen minutes
// R12 - results format is normal, summary or short
// R13 - serial rate is 300, 1200, 2400 or 4800 bps
// R14 - parity is odd, even or none
// R15 - lines end in CR or CR followed by LF
// R16 - serial port acts as the DCE side
// R17 - on sync loss the error count continues or halts per policy
// R18 - every results report also goes to history and printer buffer
// R19 - periodic timers restart from zero at test start
`timescale 1ns/10ps
module rpt_trigger
	import rpt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SECOND_CYCLES,
	parameter int unsigned CNT_W = 32
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic print_results_in,
	input wire logic print_settings_in,
	input wire logic [2:0] print_trigger_selector_in,
	input wire logic perf_option_in,
	input wire logic test_start_in,
	input wire logic timed_test_in,
	input wire logic [SEC_W-1:0] test_length_setting_in,
	input wire rpt_err_type err_event_in,
	input wire logic [7:0] alarm_state_in,
	input wire logic ber_above_limit_in,
	input wire rpt_fmt_type report_format_setting_in,
	input wire rpt_rate_type serial_rate_setting_in,
	input wire rpt_par_type serial_parity_setting_in,
	input wire logic line_ending_setting_in,
	input wire logic sync_loss_count_policy_in,
	input wire logic sync_lost_in,
	input wire logic bit_error_in,
	input wire logic formatter_busy_in,
	input wire logic line_end_req_in,
	input wire logic char_ready_in,
	output logic report_start_out,
	output rpt_req_type report_req_out,
	output logic history_wr_out,
	output logic printer_buf_wr_out,
	output logic flush_out,
	output logic test_done_out,
	output rpt_serial_type serial_cfg_out,
	output logic char_valid_out,
	output logic [7:0] char_out,
	output logic line_end_busy_out,
	output logic [CNT_W-1:0] bit_error_count_out
);

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [SEC_W-1:0] QH_LAST = SEC_W'(QUARTER_HOUR_S - 1);
	localparam logic [SEC_W-1:0] TH_LAST = SEC_W'(TWO_HOUR_S - 1);

	// pins pass three flops; stage two is read, stage three only for edge detection
	logic res_m_q, res_s_q, res_d_q;
	logic set_m_q, set_s_q, set_d_q;
	logic [2:0] sel_m_q, sel_s_q, sel_d_q;
	logic [7:0] alarm_q;
	logic ber_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic tick;
	logic [SEC_W-1:0] qh_cnt_q, th_cnt_q, test_cnt_q;
	logic test_run_q;
	logic pend_res_q, pend_set_q;
	logic auto_trig, manual_res, manual_set, to_off;
	rpt_sel_type sel;
	rpt_term_type term_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			res_m_q <= 1'b0;
			res_s_q <= 1'b0;
			set_m_q <= 1'b0;
			set_s_q <= 1'b0;
			sel_m_q <= 3'h0;
			sel_s_q <= 3'h0;
		end else begin
			res_m_q <= print_results_in;
			res_s_q <= res_m_q;
			set_m_q <= print_settings_in;
			set_s_q <= set_m_q;
			sel_m_q <= print_trigger_selector_in;
			sel_s_q <= sel_m_q;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			res_d_q <= 1'b0;
			set_d_q <= 1'b0;
			sel_d_q <= 3'h0;
			alarm_q <= 8'h00;
			ber_q <= 1'b0;
		end else begin
			res_d_q <= res_s_q;
			set_d_q <= set_s_q;
			sel_d_q <= sel_s_q;
			alarm_q <= alarm_state_in;
			ber_q <= ber_above_limit_in;
		end
	end

	assign sel = rpt_sel_type'(sel_s_q);
	assign manual_res = res_s_q & ~res_d_q; // [R1]
	assign manual_set = set_s_q & ~set_d_q; // [R2]
	assign to_off = (sel_s_q == SEL_OFF) && (sel_d_q != SEL_OFF); // [R5]

	// one-second tick; everything long is counted in seconds
	assign tick = (tick_cnt_q == TICK_LAST);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || test_start_in) begin
			tick_cnt_q <= '0; // [R19]
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || test_start_in) begin
			qh_cnt_q <= '0; // [R19]
			th_cnt_q <= '0;
		end else if (tick) begin
			qh_cnt_q <= (qh_cnt_q == QH_LAST) ? '0 : qh_cnt_q + 1'b1; // [R11]
			th_cnt_q <= (th_cnt_q == TH_LAST) ? '0 : th_cnt_q + 1'b1; // [R10]
		end
	end

	// timed test length tracked here so expiry lines up with the tick
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			test_cnt_q <= '0;
			test_run_q <= 1'b0;
			test_done_out <= 1'b0;
		end else if (test_start_in) begin
			test_cnt_q <= '0;
			test_run_q <= timed_test_in;
			test_done_out <= 1'b0;
		end else if (test_run_q && tick) begin
			test_cnt_q <= test_cnt_q + 1'b1;
			if (test_cnt_q + 1'b1 >= test_length_setting_in) begin
				test_run_q <= 1'b0; // [R6]
				test_done_out <= 1'b1;
			end else begin
				test_done_out <= 1'b0;
			end
		end else begin
			test_done_out <= 1'b0;
		end
	end

	always_comb begin
		auto_trig = 1'b0;
		case (sel) // [R3]
			SEL_OFF: auto_trig = 1'b0; // [R4]
			SEL_TEST_END: auto_trig = test_run_q && tick &&
				(test_cnt_q + 1'b1 >= test_length_setting_in); // [R6]
			SEL_ERROR: auto_trig = (|err_event_in) ||
				(alarm_state_in != alarm_q); // [R7]
			SEL_SEV_ERR: auto_trig = perf_option_in &&
				ber_above_limit_in && !ber_q; // [R8] [R9]
			SEL_TWO_HOUR: auto_trig = tick && (th_cnt_q == TH_LAST); // [R10]
			SEL_QUARTER_HOUR: auto_trig = tick &&
				(qh_cnt_q == QH_LAST); // [R11]
			default: auto_trig = 1'b0;
		endcase
	end

	// pending requests wait while the formatter is busy; a new request
	// in the flush cycle survives, only older ones are dropped
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pend_res_q <= 1'b0;
			pend_set_q <= 1'b0;
		end else begin
			if (manual_res || auto_trig) begin
				pend_res_q <= 1'b1; // [R1]
			end else if (to_off) begin
				pend_res_q <= 1'b0; // [R5]
			end else if (!formatter_busy_in && !report_start_out) begin
				pend_res_q <= 1'b0;
			end
			if (manual_set) begin
				pend_set_q <= 1'b1; // [R2]
			end else if (to_off) begin
				pend_set_q <= 1'b0; // [R5]
			end else if (!formatter_busy_in && !report_start_out &&
				!pend_res_q) begin
				pend_set_q <= 1'b0;
			end
		end
	end

	// results win over settings when both wait
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			report_start_out <= 1'b0;
			report_req_out <= '0;
			history_wr_out <= 1'b0;
			printer_buf_wr_out <= 1'b0;
			flush_out <= 1'b0;
		end else begin
			flush_out <= to_off; // [R5]
			report_start_out <= 1'b0;
			history_wr_out <= 1'b0;
			printer_buf_wr_out <= 1'b0;
			if (!formatter_busy_in && !report_start_out && !to_off) begin
				if (pend_res_q) begin
					report_start_out <= 1'b1;
					report_req_out.settings <= 1'b0;
					report_req_out.fmt <= report_format_setting_in; // [R12]
					history_wr_out <= 1'b1; // [R18]
					printer_buf_wr_out <= 1'b1; // [R18]
				end else if (pend_set_q) begin
					report_start_out <= 1'b1;
					report_req_out.settings <= 1'b1; // [R2]
					report_req_out.fmt <= report_format_setting_in;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			serial_cfg_out <= '{RATE_300, PAR_NONE, 1'b0, 1'b1};
		end else begin
			serial_cfg_out.rate <= serial_rate_setting_in; // [R13]
			serial_cfg_out.parity <= serial_parity_setting_in; // [R14]
			serial_cfg_out.crlf <= line_ending_setting_in; // [R15]
			serial_cfg_out.dce <= 1'b1; // [R16]
		end
	end

	// line terminator: CR always, LF only when configured
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			term_q <= TERM_IDLE;
			char_valid_out <= 1'b0;
			char_out <= 8'h00;
			line_end_busy_out <= 1'b0;
		end else begin
			case (term_q)
				TERM_IDLE: begin
					if (line_end_req_in) begin
						term_q <= TERM_CR;
						char_valid_out <= 1'b1;
						char_out <= CHAR_CR; // [R15]
						line_end_busy_out <= 1'b1;
					end
				end
				TERM_CR: begin
					if (char_ready_in) begin
						if (serial_cfg_out.crlf) begin
							term_q <= TERM_LF;
							char_out <= CHAR_LF; // [R15]
						end else begin
							term_q <= TERM_IDLE;
							char_valid_out <= 1'b0;
							line_end_busy_out <= 1'b0;
						end
					end
				end
				TERM_LF: begin
					if (char_ready_in) begin
						term_q <= TERM_IDLE;
						char_valid_out <= 1'b0;
						line_end_busy_out <= 1'b0;
					end
				end
				default: begin
					term_q <= TERM_IDLE;
					char_valid_out <= 1'b0;
					line_end_busy_out <= 1'b0;
				end
			endcase
		end
	end

	// count saturates rather than wrapping to a misleading small value
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || test_start_in) begin
			bit_error_count_out <= '0;
		end else if (bit_error_in && !(sync_lost_in &&
			sync_loss_count_policy_in) && !(&bit_error_count_out)) begin
			bit_error_count_out <= bit_error_count_out + 1'b1; // [R17]
		end
	end

endmodule

// file: dv/rpt_trigger_props.sv
// Purpose: port checks of rpt_trigger
// Assumes: one clock, synchronous reset
// Notes: bound to every rpt_trigger instance
`timescale 1ns/10ps
module rpt_trigger_props
	import rpt_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [2:0] print_trigger_selector_in,
	input wire rpt_rate_type serial_rate_setting_in,
	input wire rpt_par_type serial_parity_setting_in,
	input wire logic line_end_req_in,
	input wire logic char_ready_in,
	input wire logic report_start_out,
	input wire rpt_req_type report_req_out,
	input wire logic history_wr_out,
	input wire logic printer_buf_wr_out,
	input wire logic flush_out,
	input wire rpt_serial_type serial_cfg_out,
	input wire logic char_valid_out,
	input wire logic [7:0] char_out,
	input wire logic line_end_busy_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	start_pulse_a: assert property (report_start_out |=> !report_start_out)
		else $error("start pulse too long");
	hist_pair_a: assert property (history_wr_out |->
		printer_buf_wr_out && report_start_out && !report_req_out.settings)
		else $error("history write unpaired");
	settings_nohist_a: assert property (
		report_start_out && report_req_out.settings |-> !history_wr_out)
		else $error("settings report stored");
	cfg_copy_a: assert property (!$past(srst_in) |->
		serial_cfg_out.rate == $past(serial_rate_setting_in) &&
		serial_cfg_out.parity == $past(serial_parity_setting_in))
		else $error("serial settings not copied");
	dce_side_a: assert property (!$past(srst_in) |-> serial_cfg_out.dce)
		else $error("port not dce");
	flush_off_a: assert property ($past(print_trigger_selector_in) != 3'h0 &&
		print_trigger_selector_in == 3'h0 |-> ##[1:4] flush_out)
		else $error("no flush on off");
	cr_first_a: assert property (line_end_req_in && !line_end_busy_out &&
		!char_valid_out |=> char_valid_out && char_out == CHAR_CR)
		else $error("terminator not cr first");
	lf_next_a: assert property (char_valid_out && char_ready_in &&
		char_out == CHAR_CR && serial_cfg_out.crlf |=> char_out == CHAR_LF)
		else $error("lf missing after cr");
endmodule
bind rpt_trigger rpt_trigger_props u_props (.*);

// file: dv/rpt_printer_model.sv
// Purpose: formatter and printer stand-in
// Assumes: formatter goes busy after each report start
// Notes: slow mode stretches busy and paces char acceptance
`timescale 1ns/10ps
module rpt_printer_model (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic slow_in,
	input wire logic start_in,
	input wire logic valid_in,
	output logic busy_out,
	output logic ready_out
);
	logic [3:0] busy_q;
	logic tog_q;
	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			busy_q <= 4'h0;
		else if (start_in)
			busy_q <= slow_in ? 4'hc : 4'h3;
		else if (busy_q != 4'h0)
			busy_q <= busy_q - 4'h1;
	end
	always_ff @(posedge ref_clk_in) tog_q <= srst_in ? 1'b0 : ~tog_q;
	assign busy_out = busy_q != 4'h0;
	// a slow printer takes a char only every other cycle
	assign ready_out = valid_in & (~slow_in | tog_q);
endmodule

// file: dv/rpt_trigger_test.sv
// Purpose: self-checking bench of rpt_trigger
// Assumes: two-cycle tick so periodic reports fit the run
// Notes: partner model plays formatter and printer
`timescale 1ns/10ps
module rpt_trigger_test;
	import rpt_pkg::*;
	logic ref_clk_in = 1'b0, srst_in = 1'b1, print_results_in = 1'b0;
	logic print_settings_in = 1'b0, perf_option_in = 1'b0, q, slow = 1'b0;
	logic test_start_in = 1'b0, timed_test_in = 1'b0, ber_above_limit_in = 1'b0;
	logic line_ending_setting_in = 1'b1, sync_loss_count_policy_in = 1'b0;
	logic sync_lost_in = 1'b0, bit_error_in = 1'b0, line_end_req_in = 1'b0;
	logic formatter_busy_in, char_ready_in, report_start_out, history_wr_out;
	logic printer_buf_wr_out, flush_out, test_done_out, char_valid_out;
	logic line_end_busy_out;
	logic [2:0] print_trigger_selector_in = 3'h0;
	logic [SEC_W-1:0] test_length_setting_in = 24'h5;
	rpt_err_type err_event_in = 4'h0;
	logic [7:0] alarm_state_in = 8'h0, char_out;
	rpt_fmt_type report_format_setting_in = FMT_NORMAL;
	rpt_rate_type serial_rate_setting_in = RATE_4800;
	rpt_par_type serial_parity_setting_in = PAR_EVEN;
	rpt_req_type report_req_out;
	rpt_serial_type serial_cfg_out;
	logic [31:0] bit_error_count_out;
	int n_mismatch = 0, checks_done = 0, n;
	rpt_trigger #(.TICK_CYCLES(2)) dut (.*);
	rpt_printer_model partner (.ref_clk_in, .srst_in, .slow_in(slow),
		.start_in(report_start_out), .valid_in(char_valid_out),
		.busy_out(formatter_busy_in), .ready_out(char_ready_in));
	initial forever #2 ref_clk_in = ~ref_clk_in;
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// s picks start, flush, test done or char valid
	task automatic waitc(input int s, input int lim);
		logic [3:0] v;
		checks_done++;
		for (n = 1; n <= lim; n++) begin
			@(posedge ref_clk_in);
			#1 v = {char_valid_out, test_done_out, flush_out, report_start_out};
			if (v[s])
				return;
		end
		check("timeout", 1'b0, 1'b1);
		give_verdict();
	endtask
	task automatic quiet(input int k);
		q = 1'b0;
		repeat (k) begin
			@(posedge ref_clk_in);
			#1 q |= report_start_out;
		end
	endtask
	task automatic pulse(input int w);
		@(posedge ref_clk_in) print_results_in <= w[0];
		print_settings_in <= w[1];
		test_start_in <= w[2];
		bit_error_in <= w[3];
		repeat (w[3] ? w[7:4] : 4'h1) @(posedge ref_clk_in);
		{print_results_in, print_settings_in} <= 2'h0;
		{test_start_in, bit_error_in} <= 2'h0;
		quiet(2);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		quiet(2);
		check("cfg", serial_cfg_out, 6'h3b);
		for (int f = 0; f < 3; f++) begin
			report_format_setting_in <= rpt_fmt_type'(f);
			pulse(1);
			waitc(0, 20);
			check("req", report_req_out, f);
			check("store", {history_wr_out, printer_buf_wr_out}, 2'h3);
			quiet(8);
		end
		pulse(3);
		waitc(0, 20);
		check("first", report_req_out.settings, 1'b0);
		waitc(0, 20);
		check("second", {report_req_out.settings, history_wr_out}, 2'h2);
		print_trigger_selector_in <= 3'h2;
		quiet(8);
		for (int i = 0; i < 5; i++) begin
			if (i < 4)
				err_event_in <= rpt_err_type'(4'h1 << i);
			else
				alarm_state_in <= 8'h5a;
			@(posedge ref_clk_in) err_event_in <= 4'h0;
			waitc(0, 6);
			check("err lat", n <= 3, 1'b1);
			quiet(6);
		end
		print_trigger_selector_in <= 3'h3;
		quiet(4);
		ber_above_limit_in <= 1'b1;
		quiet(8);
		check("sev", q, 1'b0);
		ber_above_limit_in <= 1'b0;
		perf_option_in <= 1'b1;
		quiet(2);
		ber_above_limit_in <= 1'b1;
		waitc(0, 6);
		ber_above_limit_in <= 1'b0;
		quiet(8);
		print_trigger_selector_in <= 3'h0;
		waitc(1, 6);
		err_event_in <= 4'h8;
		alarm_state_in <= 8'h00;
		@(posedge ref_clk_in) err_event_in <= 4'h0;
		quiet(10);
		check("off", q, 1'b0);
		timed_test_in <= 1'b1;
		print_trigger_selector_in <= 3'h1;
		pulse(4);
		waitc(2, 40);
		check("len", n > 6 && n < 15, 1'b1);
		quiet(1);
		check("end rpt", q, 1'b1);
		timed_test_in <= 1'b0;
		print_trigger_selector_in <= 3'h5;
		pulse(4);
		waitc(0, 1900);
		check("15 min", n > 1790 && n < 1810, 1'b1);
		print_trigger_selector_in <= 3'h4;
		pulse(4);
		waitc(0, 14500);
		check("2 hr", n > 14390 && n < 14410, 1'b1);
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			line_ending_setting_in <= ~k[0];
			@(posedge ref_clk_in) line_end_req_in <= 1'b1;
			@(posedge ref_clk_in) line_end_req_in <= 1'b0;
			// cr stands from the edge that takes the request
			#1 check("cr", {char_valid_out, char_out}, {1'b1, CHAR_CR});
			@(posedge ref_clk_in);
			#1 check("lf", char_out, k[0] ? CHAR_CR : CHAR_LF);
			quiet(12);
			check("idle", {char_valid_out, line_end_busy_out}, 2'h0);
		end
		pulse(4);
		pulse(8'h38);
		{sync_lost_in, sync_loss_count_policy_in} <= 2'h3;
		pulse(8'h28);
		check("halt", bit_error_count_out, 32'h3);
		sync_loss_count_policy_in <= 1'b0;
		pulse(8'h28);
		check("cont", bit_error_count_out, 32'h5);
		give_verdict();
	end
endmodule
